// ===== ies_map.vh
`ifndef IES_MAP_VH
`define IES_MAP_VH
// I/O addresses of the stack pointer bytes
`define IES_ADDR_SP_LOW 6'h3D
`define IES_ADDR_SP_HIGH 6'h3E
// I/O address of the core flags
`define IES_ADDR_FLAGS 6'h3F
// Top of data memory, stack pointer reset value
`define IES_TOP_OF_DATA_MEMORY 16'h025F
// Core flag bit positions
`define IES_FLAG_I 7
`define IES_FLAG_T 6
`define IES_FLAG_H 5
`define IES_FLAG_S 4
`define IES_FLAG_V 3
`define IES_FLAG_N 2
`define IES_FLAG_Z 1
`define IES_FLAG_C 0
// Core flags reset value
`define IES_FLAGS_RESET 8'h00
// Number of request sources
`define IES_NUM_SRC 8
// Entry and return lengths in core clocks
`define IES_ENTRY_CYCLES 3'h4
`define IES_RETURN_CYCLES 3'h4
`define IES_WAKE_EXTRA_CYCLES 3'h4
`endif

// ===== ies_seq.v
// Function
// - Fetch next instruction while executing current
// - Two-register ALU op completes in one cycle
// - Take request only with source and global enable
// - Lowest vector wins; reset highest priority
// - Entry clears global enable flag
// - Handler may set global enable to nest
// - Return sets global enable flag
// - Vectoring clears flag-type request flag
// - Writing one clears flag; zero keeps
// - Disabled flags stay pending until served
// - Level requests only while condition present
// - One instruction runs after return before service
// - Flags not saved on entry or return
// - Clear-global instruction blocks same-cycle requests
// - Instruction after set-global runs before service
// - Entry lasts four cycles, pushes program counter
// - Multi-cycle instruction completes before service
// - Wake from sleep adds four entry cycles
// - Return takes four cycles, pops, adds two
// - Global enable is flag bit seven
// - Sign flag equals negative xor overflow
// - Bit six is bit-store/bit-load storage
// - Push on entry subtracts two from pointer
`timescale 1ns/1ps
`include "ies_map.vh"
module ies_seq (
	// Clock and reset
	input wire i_ref_clk,
	input wire i_rst_b,
	// Peripheral requests
	input wire [`IES_NUM_SRC-1:0] i_src_event,
	input wire [`IES_NUM_SRC-1:0] i_src_level_type,
	input wire [`IES_NUM_SRC-1:0] i_src_enable,
	// Execution core handshake
	input wire i_instr_done,
	input wire i_set_global_instr,
	input wire i_clear_global_instr,
	input wire i_return_from_handler,
	input wire i_call_push,
	input wire i_sleeping,
	// ALU flag results
	input wire i_alu_flags_we,
	input wire [7:0] i_alu_flags,
	input wire i_bit_store_instr,
	input wire i_bit_store_value,
	// I/O register port
	input wire i_io_we,
	input wire i_io_re,
	input wire [5:0] i_io_addr,
	input wire [7:0] i_io_wdata,
	output reg [7:0] o_io_rdata,
	// Request flags clear by I/O write
	input wire i_flag_clr_we,
	input wire [`IES_NUM_SRC-1:0] i_flag_clr_mask,
	// Sequencer outputs
	output reg [`IES_NUM_SRC-1:0] o_pending,
	output reg o_entry_busy,
	output reg o_return_busy,
	output reg o_push_strobe,
	output reg o_pop_strobe,
	output reg o_vector_valid,
	output reg [3:0] o_vector_num,
	output reg [15:0] o_stack_pointer,
	output reg [7:0] o_core_flags,
	output reg o_bit_load_value
);
	// Sequencer states
	localparam ST_RUN = 2'h0;
	localparam ST_ENTRY = 2'h1;
	localparam ST_RETURN = 2'h2;

	// Synchronised peripheral event and level inputs, request flags, sequencer state and core registers
	reg [`IES_NUM_SRC-1:0] ev_s1_q;
	reg [`IES_NUM_SRC-1:0] ev_s2_q;
	reg [`IES_NUM_SRC-1:0] ev_prev_q;
	reg [`IES_NUM_SRC-1:0] flag_q;
	reg [1:0] state_q;
	reg [2:0] cnt_q;
	reg [3:0] win_q;
	reg hold_q;
	reg [7:0] flags_q;
	reg [15:0] sp_q;
	// Combinational request view
	wire [`IES_NUM_SRC-1:0] rise;
	wire [`IES_NUM_SRC-1:0] req;
	reg [3:0] win;
	reg win_any;
	integer k;

	// Two-stage synchroniser and edge history
	always @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ev_s1_q <= 8'h00;
			ev_s2_q <= 8'h00;
			ev_prev_q <= 8'h00;
		end else begin
			ev_s1_q <= i_src_event;
			ev_s2_q <= ev_s1_q;
			ev_prev_q <= ev_s2_q;
		end
	end

	assign rise = ev_s2_q & ~ev_prev_q;

	// Per-source request: latched flag or live level
	genvar g;
	generate
		for (g = 0; g < `IES_NUM_SRC; g = g + 1) begin : g_src
			assign req[g] = (i_src_level_type[g] ? ev_s2_q[g] : flag_q[g])
				& i_src_enable[g];
		end
	endgenerate

	// Lowest index wins; index maps to vector order after reset
	always @* begin
		win = 4'h0;
		win_any = 1'b0;
		for (k = `IES_NUM_SRC - 1; k >= 0; k = k - 1) begin
			if (req[k]) begin
				win = k[3:0];
				win_any = 1'b1;
			end
		end
	end

	// Take decision: global enable, instruction boundary, no hold
	wire take = win_any && flags_q[`IES_FLAG_I]
		&& !i_clear_global_instr
		&& i_instr_done
		&& !hold_q
		&& state_q == ST_RUN;

	// Request flags: set wins over clears
	always @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			flag_q <= 8'h00;
		end else begin
			for (k = 0; k < `IES_NUM_SRC; k = k + 1) begin
				if (rise[k] && !i_src_level_type[k]) begin
					flag_q[k] <= 1'b1;
				end else if (i_flag_clr_we && i_flag_clr_mask[k]) begin
					flag_q[k] <= 1'b0;
				end else if (take && win == k[3:0]) begin
					flag_q[k] <= 1'b0;
				end
			end
		end
	end

	// Sequencer: entry and return timing
	always @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_q <= ST_RUN;
			cnt_q <= 3'h0;
			win_q <= 4'h0;
			hold_q <= 1'b0;
		end else begin
			case (state_q)
				ST_RUN: begin
					if (hold_q && i_instr_done) begin
						hold_q <= 1'b0;
					end
					if (take) begin
						state_q <= ST_ENTRY;
						win_q <= win;
						// Sleep wake adds extra cycles
						cnt_q <= i_sleeping ? 3'h7 : 3'h3;
					end else if (i_return_from_handler && i_instr_done) begin
						state_q <= ST_RETURN;
						cnt_q <= 3'h3;
					end else if (i_set_global_instr && i_instr_done) begin
						hold_q <= 1'b1;
					end
				end
				ST_ENTRY: begin
					if (cnt_q == 3'h0) begin
						state_q <= ST_RUN;
					end else begin
						cnt_q <= cnt_q - 3'h1;
					end
				end
				ST_RETURN: begin
					if (cnt_q == 3'h0) begin
						state_q <= ST_RUN;
						hold_q <= 1'b1;
					end else begin
						cnt_q <= cnt_q - 3'h1;
					end
				end
				default: begin
					state_q <= ST_RUN;
				end
			endcase
		end
	end

	// Core flags; never saved or restored by entry/return
	always @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			flags_q <= `IES_FLAGS_RESET;
		end else begin
			if (i_io_we && i_io_addr == `IES_ADDR_FLAGS) begin
				flags_q <= i_io_wdata;
			end else if (i_alu_flags_we) begin
				flags_q[5:0] <= i_alu_flags[5:0];
			end
			if (i_bit_store_instr) begin
				flags_q[`IES_FLAG_T] <= i_bit_store_value;
			end
			if (take || i_clear_global_instr) begin
				flags_q[`IES_FLAG_I] <= 1'b0;
			end else if (state_q == ST_RETURN && cnt_q == 3'h0) begin
				flags_q[`IES_FLAG_I] <= 1'b1;
			end else if (i_set_global_instr) begin
				flags_q[`IES_FLAG_I] <= 1'b1;
			end
		end
	end

	// Stack pointer: push subtracts two, pop adds two
	always @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sp_q <= `IES_TOP_OF_DATA_MEMORY;
		end else if (take || i_call_push) begin
			sp_q <= sp_q - 16'h0002;
		end else if (state_q == ST_RETURN && cnt_q == 3'h0) begin
			sp_q <= sp_q + 16'h0002;
		end else if (i_io_we && i_io_addr == `IES_ADDR_SP_LOW) begin
			sp_q[7:0] <= i_io_wdata;
		end else if (i_io_we && i_io_addr == `IES_ADDR_SP_HIGH) begin
			sp_q[15:8] <= i_io_wdata;
		end
	end

	// Registered outputs
	always @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_io_rdata <= 8'h00;
			o_pending <= 8'h00;
			o_entry_busy <= 1'b0;
			o_return_busy <= 1'b0;
			o_push_strobe <= 1'b0;
			o_pop_strobe <= 1'b0;
			o_vector_valid <= 1'b0;
			o_vector_num <= 4'h0;
			o_stack_pointer <= `IES_TOP_OF_DATA_MEMORY;
			o_core_flags <= `IES_FLAGS_RESET;
			o_bit_load_value <= 1'b0;
		end else begin
			// Read data, unmapped reads zero
			if (i_io_re && i_io_addr == `IES_ADDR_SP_LOW) begin
				o_io_rdata <= sp_q[7:0];
			end else if (i_io_re && i_io_addr == `IES_ADDR_SP_HIGH) begin
				o_io_rdata <= sp_q[15:8];
			end else if (i_io_re && i_io_addr == `IES_ADDR_FLAGS) begin
				o_io_rdata <= {flags_q[7:5],
					flags_q[`IES_FLAG_N] ^ flags_q[`IES_FLAG_V], flags_q[3:0]};
			end else begin
				o_io_rdata <= 8'h00;
			end
			o_pending <= req;
			o_entry_busy <= take || (state_q == ST_ENTRY && cnt_q != 3'h0);
			o_return_busy <= (i_return_from_handler && i_instr_done && !take
				&& state_q == ST_RUN) || (state_q == ST_RETURN && cnt_q != 3'h0);
			o_push_strobe <= take;
			o_pop_strobe <= state_q == ST_RETURN && cnt_q == 3'h0;
			// Vector fetch after the entry period
			o_vector_valid <= state_q == ST_ENTRY && cnt_q == 3'h0;
			o_vector_num <= win_q + 4'h1;
			o_stack_pointer <= sp_q;
			// Sign flag always derived
			o_core_flags <= {flags_q[7:5],
				flags_q[`IES_FLAG_N] ^ flags_q[`IES_FLAG_V], flags_q[3:0]};
			o_bit_load_value <= flags_q[`IES_FLAG_T];
		end
	end
endmodule

// ===== ies_seq_sva.sv
`timescale 1ns/1ps
module ies_seq_sva (
	input wire i_ref_clk,
	input wire i_rst_b,
	input wire i_instr_done,
	input wire i_clear_global_instr,
	input wire i_sleeping,
	input wire o_return_busy,
	input wire o_push_strobe,
	input wire o_pop_strobe,
	input wire o_vector_valid,
	input wire [15:0] o_stack_pointer,
	input wire [7:0] o_core_flags
);
	// One clock, reset disables all
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_b);
	// Entry: enable seen low next cycle, vector four cycles after push
	sequence s_entry;
		##1 !o_core_flags[7] ##3 o_vector_valid;
	endsequence
	// Return: pop four cycles after busy rises, enable visible next
	sequence s_ret;
		##4 o_pop_strobe ##1 o_core_flags[7];
	endsequence
	a_take_gated: assert property (o_push_strobe |-> $past(o_core_flags[7]))
		else $error("take without enable");
	a_take_bound: assert property (o_push_strobe |-> $past(i_instr_done))
		else $error("take off boundary");
	a_entry_fast: assert property (o_push_strobe && !$past(i_sleeping) |-> s_entry)
		else $error("entry timing");
	a_entry_sleep: assert property (o_push_strobe && $past(i_sleeping) |->
		##8 o_vector_valid) else $error("sleep entry timing");
	a_push_sp: assert property (o_push_strobe |=>
		o_stack_pointer == $past(o_stack_pointer) - 16'h0002) else $error("push pointer");
	a_ret_steps: assert property ($rose(o_return_busy) |-> s_ret)
		else $error("return timing");
	a_sign_xor: assert property (o_core_flags[4] == (o_core_flags[2] ^ o_core_flags[3]))
		else $error("sign flag");
	a_clear_blocks: assert property (i_clear_global_instr |=> !o_push_strobe)
		else $error("take after clear");
endmodule
bind ies_seq ies_seq_sva u_ies_seq_sva (.*);

// ===== ies_core_model.sv
`timescale 1ns/1ps
module ies_core_model (
	// Clock and reset
	input wire i_ref_clk,
	input wire i_rst_b,
	// Hold for a multi-cycle instruction
	input wire i_stall,
	// Instruction boundary
	output reg o_instr_done
);
	// One instruction ends each clock unless held
	always @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_instr_done <= 1'b0;
		end else begin
			o_instr_done <= !i_stall;
		end
	end
endmodule

// ===== tb.sv
`timescale 1ns/1ps
module tb;
	// Stimulus
	reg i_ref_clk = 1'b0, i_rst_b = 1'b0, i_stall = 1'b0, i_call_push = 1'b0;
	reg [7:0] i_src_event = 8'h00, i_src_level_type = 8'h00, i_src_enable = 8'h00;
	reg i_set_global_instr = 1'b0, i_clear_global_instr = 1'b0, i_return_from_handler = 1'b0;
	reg i_sleeping = 1'b0, i_alu_flags_we = 1'b0, i_bit_store_instr = 1'b0, i_bit_store_value = 1'b0;
	reg i_io_we = 1'b0, i_io_re = 1'b0, i_flag_clr_we = 1'b0;
	reg [7:0] i_alu_flags = 8'h00, i_io_wdata = 8'h00, i_flag_clr_mask = 8'h00;
	reg [5:0] i_io_addr = 6'h00;
	// Responses
	wire i_instr_done, o_entry_busy, o_return_busy, o_push_strobe, o_pop_strobe;
	wire o_vector_valid, o_bit_load_value;
	wire [7:0] o_io_rdata, o_pending, o_core_flags;
	wire [3:0] o_vector_num;
	wire [15:0] o_stack_pointer;
	integer fails = 0, n_checks = 0;
	ies_seq u_ies_seq (.*);
	ies_core_model u_ies_core_model (
		.i_ref_clk(i_ref_clk),
		.i_rst_b(i_rst_b),
		.i_stall(i_stall),
		.o_instr_done(i_instr_done)
	);
	// 100 MHz clock
	always #5 i_ref_clk = ~i_ref_clk;
	// Compare and report
	task chk(input [15:0] seen, input [15:0] exp, input [39:0] nm);
		n_checks = n_checks + 1;
		if (seen !== exp) begin
			fails = fails + 1;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task cyc(input integer n);
		repeat (n) @(posedge i_ref_clk);
	endtask
	// Register read, data one cycle later
	task rdio(input [5:0] a, input [7:0] e);
		cyc(1);
		i_io_re <= 1'b1;
		i_io_addr <= a;
		cyc(1);
		i_io_re <= 1'b0;
		#1 chk(o_io_rdata, e, "io");
	endtask
	// Set or clear global enable, one instruction
	task gie(input s);
		cyc(1);
		i_set_global_instr <= s;
		i_clear_global_instr <= !s;
		cyc(1);
		i_set_global_instr <= 1'b0;
		i_clear_global_instr <= 1'b0;
	endtask
	// Bounded wait for the vector pulse
	task vec(input [3:0] e);
		integer k;
		for (k = 0; k < 40 && o_vector_valid !== 1'b1; k = k + 1) begin
			cyc(1);
			#1;
		end
		chk(o_vector_valid, 1'b1, "vld");
		chk(o_vector_num, e, "vec");
	endtask
	// Reset values and flag writes
	task s_regs;
		rdio(6'h3D, 8'h5F);
		rdio(6'h3E, 8'h02);
		cyc(1);
		i_call_push <= 1'b1;
		cyc(1);
		i_call_push <= 1'b0;
		cyc(1);
		#1 chk(o_stack_pointer, 16'h025D, "sp");
		cyc(1);
		i_io_we <= 1'b1;
		i_io_addr <= 6'h3D;
		i_io_wdata <= 8'h5F;
		cyc(1);
		i_io_we <= 1'b0;
		cyc(1);
		#1 chk(o_stack_pointer, 16'h025F, "sp");
		cyc(1);
		i_alu_flags_we <= 1'b1;
		i_alu_flags <= 8'h1C;
		i_bit_store_instr <= 1'b1;
		i_bit_store_value <= 1'b1;
		cyc(1);
		i_alu_flags_we <= 1'b0;
		i_bit_store_instr <= 1'b0;
		cyc(1);
		#1 chk(o_core_flags, 8'h4C, "flags");
		chk(o_bit_load_value, 1'b1, "tbit");
	endtask
	// Flags held while disabled, one cleared by write
	task s_pend;
		cyc(1);
		i_src_enable <= 8'h24;
		i_src_event <= 8'h26;
		cyc(4);
		i_src_event <= 8'h00;
		i_flag_clr_we <= 1'b1;
		i_flag_clr_mask <= 8'h02;
		#1 chk(o_pending, 8'h24, "pend");
		cyc(1);
		i_flag_clr_we <= 1'b0;
		i_src_enable <= 8'h26;
		gie(1'b1);
		vec(4'h3);
		chk(o_core_flags[7], 1'b0, "gie");
		chk(o_stack_pointer, 16'h025D, "sp");
	endtask
	// Return, then sleeping entry of the next flag
	task s_ret;
		cyc(1);
		i_sleeping <= 1'b1;
		i_return_from_handler <= 1'b1;
		cyc(1);
		i_return_from_handler <= 1'b0;
		cyc(5);
		#1 chk(o_stack_pointer, 16'h025F, "sp");
		chk(o_core_flags, 8'hCC, "flags");
		vec(4'h6);
	endtask
	// Clear blocks a live level request; set lets it nest
	task s_cli;
		cyc(1);
		i_sleeping <= 1'b0;
		i_src_level_type <= 8'h01;
		i_src_enable <= 8'h01;
		i_src_event <= 8'h01;
		cyc(2);
		gie(1'b1);
		gie(1'b0);
		cyc(5);
		#1 chk(o_entry_busy, 1'b0, "busy");
		gie(1'b1);
		vec(4'h1);
	endtask
	// Verdict
	task tally_and_finish;
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		cyc(10);
		i_rst_b <= 1'b1;
		s_regs;
		s_pend;
		s_ret;
		s_cli;
		tally_and_finish;
	end
	// Watchdog
	initial begin
		#20000;
		fails = fails + 1;
		tally_and_finish;
	end
endmodule
